// file: verilog/sspm_pkg.sv
// package for the seven-stage pipeline sequencer and operating mode register
// assumes a single core clock and a synchronous active-low reset in the user
package sspm_pkg;

    localparam int OMR_W = 24;
    localparam int PC_W = 24;
    localparam int INSTR_W = 24;

    // byte sections of the operating mode register
    localparam int SCS_LSB = 16;
    localparam int EOM_LSB = 8;
    localparam int BYTE_W = 8;

    // field positions
    localparam int SEN_BIT = 20;
    localparam int CDP_LSB = 8;
    localparam int MODE_PIN_W = 4;

    // value after reset apart from the mode pins (bits 9 and 8 set)
    localparam logic [23:0] OMR_RST = 24'h000300;
    // implemented bits; bit 5 is reserved and reads as zero
    localparam logic [23:0] OMR_IMPL = 24'hffffdf;

    // pipeline stage indices
    localparam int ST_F1 = 0;
    localparam int ST_F2 = 1;
    localparam int ST_DEC = 2;
    localparam int ST_AG1 = 3;
    localparam int ST_AG2 = 4;
    localparam int ST_EX1 = 5;
    localparam int ST_EX2 = 6;
    localparam int N_STAGES = 7;

    // write operations on the mode register
    typedef enum logic [2:0] {
        SSPM_WR_NONE = 3'b000,
        SSPM_WR_MOVE = 3'b001,
        SSPM_WR_AND = 3'b010,
        SSPM_WR_OR = 3'b011,
        SSPM_WR_SCS = 3'b100
    } sspm_wr_t;

endpackage : sspm_pkg

// file: verilog/sspm_core.sv
// seven-stage pipeline sequencer with the operating mode register
// assumes program memory answers one cycle after the fetch address; hazard detect
// signals come from the execution units on the same clock
//
// Operation
// - seven stages each hold their own instruction at once.
// - first fetch stage drives fetch address and increments program counter.
// - second fetch stage reads the instruction word; decode stage follows.
// - address stage one forms data address; stage two updates the pointer.
// - execute one reads operands and store source, multiplies, writes load target.
// - execute two rereads adder operands, adds, writes adder and multiplier results.
// - interlocks resolve hazards automatically, costing only extra cycles.
// - mode register is 24 bits in three byte sections.
// - stack byte written implicitly by loop, call, return or by register move.
// - mode bytes change only on reset or explicit and, or, move writes.
// - during reset the four chip mode bits load from the mode pins.
// - reset value: bits 9 and 8 one, bits 3..0 pins, rest zero.
// - reserved bits, bit 5 among them, always read zero.
// - bit 20 enables the stack extension and resets cleared.
`timescale 1ns/100ps
`default_nettype none

module sspm_core #(
    parameter int PC_W = sspm_pkg::PC_W,
    parameter int INSTR_W = sspm_pkg::INSTR_W,
    parameter logic [23:0] PC_RESET = 24'h000000
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // mode select pins
    input wire logic [3:0] i_mode_select_pin,
    // program memory
    input wire logic [INSTR_W-1:0] i_pmem_data,
    output logic [PC_W-1:0] o_pmem_addr,
    output logic o_pmem_rd,
    // hazards per stage from the execution unit interlocks
    input wire logic [6:0] i_hazard,
    // mode register access
    input wire sspm_pkg::sspm_wr_t i_omr_wr_op,
    input wire logic [23:0] i_omr_wr_data,
    input wire logic [7:0] i_scs_wr_data,
    output logic [23:0] o_operating_mode_register,
    output logic o_stack_extension_enable,
    // pipeline view
    output logic [6:0] o_stage_valid,
    output logic [6:0] o_stage_advance,
    output logic [INSTR_W-1:0] o_dec_instr,
    output logic [PC_W-1:0] o_program_counter,
    output logic o_stall
);

    localparam int NS = sspm_pkg::N_STAGES;
    localparam int LAST = NS - 1;
    localparam int PIN_W = sspm_pkg::MODE_PIN_W;
    localparam int OMR_W = sspm_pkg::OMR_W;
    localparam int BW = sspm_pkg::BYTE_W;

    // short stage names; index 0 is the first fetch stage and
    // the highest index is the last execute stage
    localparam int S_F1 = sspm_pkg::ST_F1;
    localparam int S_F2 = sspm_pkg::ST_F2;
    localparam int S_DEC = sspm_pkg::ST_DEC;
    localparam int S_AG1 = sspm_pkg::ST_AG1;
    localparam int S_AG2 = sspm_pkg::ST_AG2;
    localparam int S_EX1 = sspm_pkg::ST_EX1;
    localparam int S_EX2 = sspm_pkg::ST_EX2;

    // the whole state of the block is one record, registered once per clock
    typedef struct packed {
        // mode pin synchroniser and the last level on which two flops agreed
        logic [PIN_W-1:0] pin_s1;
        logic [PIN_W-1:0] pin_s2;
        logic [PIN_W-1:0] pin_s3;
        logic [PIN_W-1:0] pin_q;
        // operating mode register
        logic [OMR_W-1:0] operating_mode_register;
        // fetch side
        logic [PC_W-1:0] pc;
        logic [PC_W-1:0] fetch_addr;
        logic fetch_rd;
        // stage occupancy and contents
        logic [NS-1:0] valid;
        logic [NS-1:0] advance;
        logic [NS-1:0][INSTR_W-1:0] instr;
        logic stall;
    } sspm_state_t;

    // present state and the value it takes at the next edge
    sspm_state_t st_r;
    sspm_state_t st_nxt;

    // a stage holds if its own hazard or any later stage holds; a bubble's own hazard is ignored,
    // so an empty stage cannot block the instructions behind it
    function automatic logic [NS-1:0] hold_mask(input logic [NS-1:0] haz,
                                                 input logic [NS-1:0] vld);
        logic [NS-1:0] h;
        h = '0;
        h[LAST] = haz[LAST] & vld[LAST];
        for (int k = LAST - 1; k >= 0; k--)
        begin
            h[k] = (haz[k] & vld[k]) | h[k+1];
        end
        return h;
    endfunction : hold_mask

    // stage k receives an instruction when stage k-1 has one and is free
    // to pass it on; otherwise it receives a bubble
    function automatic logic feeds(input logic [NS-1:0] vld,
                                   input logic [NS-1:0] h,
                                   input int k);
        return vld[k-1] & ~h[k-1];
    endfunction : feeds

    // a new pin level counts only once the second and third flops agree,
    // so a pin caught mid-transition never reaches the mode bits
    function automatic logic [PIN_W-1:0] pin_agreed(input sspm_state_t s);
        logic [PIN_W-1:0] q;
        q = s.pin_q;
        if (s.pin_s2 == s.pin_s3)
        begin
            q = s.pin_s3;
        end
        return q;
    endfunction : pin_agreed

    // reset value of the mode register: fixed bits plus the agreed pins;
    // the pins are only looked at while reset is held
    function automatic logic [OMR_W-1:0] omr_reset(input logic [PIN_W-1:0] pins);
        logic [OMR_W-1:0] r;
        r = sspm_pkg::OMR_RST;
        r[PIN_W-1:0] = pins;
        return r;
    endfunction : omr_reset

    // one write on the mode register; reserved bits are cleared by the caller
    // so that no write path can ever set them
    function automatic logic [OMR_W-1:0] omr_write(input sspm_pkg::sspm_wr_t op,
                                                   input logic [OMR_W-1:0] cur,
                                                   input logic [OMR_W-1:0] wdat,
                                                   input logic [BW-1:0] sdat);
        logic [OMR_W-1:0] r;
        r = cur;
        unique case (op)
            sspm_pkg::SSPM_WR_NONE: r = cur;
            // explicit writes naming the register reach every byte
            sspm_pkg::SSPM_WR_MOVE: r = wdat;
            sspm_pkg::SSPM_WR_AND: r = cur & wdat;
            sspm_pkg::SSPM_WR_OR: r = cur | wdat;
            // loop, call and return touch only the stack byte
            sspm_pkg::SSPM_WR_SCS:
            begin
                r = cur;
                r[sspm_pkg::SCS_LSB +: BW] = sdat;
            end
            // unused codes leave the register alone
            default: r = cur;
        endcase
        return r;
    endfunction : omr_write

    // stages held at this edge
    logic [NS-1:0] hold;
    // enter[k]: stage k receives an instruction at this edge
    logic [NS-1:0] enter;

    always_comb
    begin
        st_nxt = st_r;
        hold = hold_mask(i_hazard, st_r.valid);

        // three-flop pin synchroniser; the first flop feeds only the second
        st_nxt.pin_s1 = i_mode_select_pin;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.pin_s3 = st_r.pin_s2;
        st_nxt.pin_q = pin_agreed(st_r);

        // stage k moves on this edge when it is free and something arrives
        // from stage k-1; the first fetch stage moves whenever it is free
        enter = '0;
        for (int k = 1; k < NS; k++)
        begin
            enter[k] = feeds(st_r.valid, hold, k) & ~hold[k];
        end
        enter[S_F1] = ~hold[S_F1];

        // second execute stage: adder operands reread, add, and both
        // results written back; the units act on the word held here;
        // a held stage keeps its record through st_nxt = st_r
        if (!hold[S_EX2])
        begin
            st_nxt.valid[S_EX2] = feeds(st_r.valid, hold, S_EX2);
            st_nxt.instr[S_EX2] = st_r.instr[S_EX1];
        end

        // first execute stage: operand and store source reads, multiply,
        // load write-back; the units act on the word held here
        // and see it for exactly one cycle unless held
        if (!hold[S_EX1])
        begin
            st_nxt.valid[S_EX1] = feeds(st_r.valid, hold, S_EX1);
            st_nxt.instr[S_EX1] = st_r.instr[S_AG2];
        end

        // second address stage: pointer update on the word held here;
        // a hazard here freezes it and everything before it
        // while the execute stages drain
        if (!hold[S_AG2])
        begin
            st_nxt.valid[S_AG2] = feeds(st_r.valid, hold, S_AG2);
            st_nxt.instr[S_AG2] = st_r.instr[S_AG1];
        end

        // first address stage: data address for loads and stores
        // is formed from the word held here
        // by the address unit
        if (!hold[S_AG1])
        begin
            st_nxt.valid[S_AG1] = feeds(st_r.valid, hold, S_AG1);
            st_nxt.instr[S_AG1] = st_r.instr[S_DEC];
        end

        // decode stage takes the word captured by the second fetch stage;
        // its content is shown on the decode output
        // one cycle after capture
        if (!hold[S_DEC])
        begin
            st_nxt.valid[S_DEC] = feeds(st_r.valid, hold, S_DEC);
            st_nxt.instr[S_DEC] = st_r.instr[S_F2];
        end

        // second fetch stage captures the word on the program memory bus;
        // the fetch address stays put while this stage is held, so the
        // pending word is still on the bus when it moves again
        if (!hold[S_F2])
        begin
            st_nxt.valid[S_F2] = feeds(st_r.valid, hold, S_F2);
            st_nxt.instr[S_F2] = i_pmem_data;
        end

        // first fetch stage: issue the next address and step the counter
        st_nxt.valid[S_F1] = 1'b1;
        st_nxt.fetch_rd = ~hold[S_F1];
        if (!hold[S_F1])
        begin
            st_nxt.fetch_addr = st_r.pc;
            st_nxt.pc = st_r.pc + PC_W'(1);
            st_nxt.instr[S_F1] = '0;
        end

        // without a hazard the first fetch stage and every stage with a valid predecessor move each clock
        st_nxt.advance = enter;
        st_nxt.stall = |hold;

        // mode register: operating bytes change only through explicit writes
        st_nxt.operating_mode_register = omr_write(i_omr_wr_op,
                               st_r.operating_mode_register,
                               i_omr_wr_data,
                               i_scs_wr_data) & sspm_pkg::OMR_IMPL;

        // synchronous reset; the pin synchroniser keeps running through it so
        // the mode bits are settled by the time reset is released
        if (!i_rst_n)
        begin
            st_nxt = '0;
            st_nxt.pc = PC_RESET[PC_W-1:0];
            st_nxt.operating_mode_register = omr_reset(st_r.pin_q) & sspm_pkg::OMR_IMPL;
            st_nxt.pin_s1 = i_mode_select_pin;
            st_nxt.pin_s2 = st_r.pin_s1;
            st_nxt.pin_s3 = st_r.pin_s2;
            st_nxt.pin_q = pin_agreed(st_r);
        end
    end

    // the single register of the block
    always_ff @(posedge i_clk)
    begin
        st_r <= st_nxt;
    end

    // every output comes straight from a flop of the state record
    // program memory side
    assign o_pmem_addr = st_r.fetch_addr;
    assign o_pmem_rd = st_r.fetch_rd;
    assign o_program_counter = st_r.pc;

    // mode register and the field that leaves the block on its own
    assign o_operating_mode_register = st_r.operating_mode_register;
    assign o_stack_extension_enable = st_r.operating_mode_register[sspm_pkg::SEN_BIT];

    // pipeline view; seven records move side by side
    assign o_stage_valid = st_r.valid;
    assign o_stage_advance = st_r.advance;
    assign o_dec_instr = st_r.instr[S_DEC];
    assign o_stall = st_r.stall;

endmodule : sspm_core

`default_nettype wire

// file: tb/sspm_core_chk.sv
// timing checks on the sequencer and the mode register
// assumes it is bound to sspm_core with default widths
`timescale 1ns/100ps
`default_nettype none
module sspm_core_chk (
    // watched ports
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [6:0] i_hazard,
    input wire sspm_pkg::sspm_wr_t i_omr_wr_op,
    input wire logic [23:0] i_omr_wr_data,
    input wire logic [7:0] i_scs_wr_data,
    input wire logic [23:0] o_operating_mode_register,
    input wire logic o_stack_extension_enable,
    input wire logic [6:0] o_stage_valid,
    input wire logic [6:0] o_stage_advance,
    input wire logic [23:0] o_pmem_addr,
    input wire logic o_pmem_rd,
    input wire logic o_stall
);
    wire [23:0] m = o_operating_mode_register;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_two_fetch;
        o_pmem_rd ##1 o_pmem_rd;
    endsequence
    property p_fetch; s_two_fetch |-> o_pmem_addr == $past(o_pmem_addr) + 24'h1; endproperty
    property p_rsvd; !m[5]; endproperty
    property p_sen; o_stack_extension_enable == m[20]; endproperty
    property p_move; i_omr_wr_op == sspm_pkg::SSPM_WR_MOVE |=> m == ($past(i_omr_wr_data) & 24'hffffdf); endproperty
    property p_and; i_omr_wr_op == sspm_pkg::SSPM_WR_AND |=> m == $past(m & i_omr_wr_data); endproperty
    property p_or; i_omr_wr_op == sspm_pkg::SSPM_WR_OR |=> m == ($past(m | i_omr_wr_data) & 24'hffffdf); endproperty
    property p_scs; i_omr_wr_op == sspm_pkg::SSPM_WR_SCS |=> m == {$past(i_scs_wr_data), $past(m[15:0])}; endproperty
    property p_keep; i_omr_wr_op == sspm_pkg::SSPM_WR_NONE |=> $stable(m[15:0]); endproperty
    property p_flow; i_hazard == 7'h00 |=> !o_stall && o_stage_valid[6:1] == $past(o_stage_valid[5:0]); endproperty
    property p_hold;
        i_hazard == 7'h08 && o_stage_valid[3] |=> o_stall && o_stage_valid[3] && !o_stage_advance[4]
            && o_stage_advance[6:5] == $past(o_stage_valid[5:4]);
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch address not consecutive");
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    a_sen: assert property (p_sen) else $error("extension enable differs from bit 20");
    a_move: assert property (p_move) else $error("move result wrong");
    a_and: assert property (p_and) else $error("and result wrong");
    a_or: assert property (p_or) else $error("or result wrong");
    a_scs: assert property (p_scs) else $error("stack byte write wrong");
    a_keep: assert property (p_keep) else $error("mode bytes changed without write");
    a_flow: assert property (p_flow) else $error("stages did not advance");
    a_hold: assert property (p_hold) else $error("stall handling wrong");
endmodule : sspm_core_chk
bind sspm_core sspm_core_chk i_sspm_core_chk (.*);
`default_nettype wire

// file: tb/sspm_core_bench.sv
// self-checking bench for the sequencer and mode register
// assumes sspm_core with default parameters; inputs change on falling edges
`timescale 1ns/100ps
`default_nettype none
module sspm_core_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] pins = 4'ha;
    logic [23:0] pmem = 24'h0;
    logic [6:0] haz = 7'h0;
    sspm_pkg::sspm_wr_t op = sspm_pkg::SSPM_WR_NONE;
    logic [23:0] wdat = 24'h0;
    logic [7:0] sdat = 8'h0;
    logic [23:0] operating_mode_register, addr;
    logic stack_extension_enable, rd, stall;
    logic [6:0] vld, adv;
    logic [23:0] dec, pc;
    int err_total = 0;
    int num_checks = 0;
    sspm_core i_sspm_core (.i_clk(clk), .i_rst_n(rst_n), .i_mode_select_pin(pins),
        .i_pmem_data(pmem), .o_pmem_addr(addr), .o_pmem_rd(rd), .i_hazard(haz),
        .i_omr_wr_op(op), .i_omr_wr_data(wdat), .i_scs_wr_data(sdat),
        .o_operating_mode_register(operating_mode_register), .o_stack_extension_enable(stack_extension_enable),
        .o_stage_valid(vld), .o_stage_advance(adv), .o_dec_instr(dec), .o_program_counter(pc),
        .o_stall(stall));
    initial forever #2 clk = ~clk;
    // program memory answers with a word derived from the address
    always @(negedge clk) pmem <= addr ^ 24'h5a5a5a;
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input sspm_pkg::sspm_wr_t o, input logic [23:0] d, input logic [7:0] s);
        @(negedge clk);
        op = o;
        wdat = d;
        sdat = s;
        @(negedge clk);
        op = sspm_pkg::SSPM_WR_NONE;
    endtask : wr
    task automatic do_reset(input logic [3:0] p);
        @(negedge clk);
        pins = p;
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        chk("omr reset", {20'h00030, p}, operating_mode_register);
        chk("sen reset", 24'h0, {23'h0, stack_extension_enable});
        @(negedge clk);
        chk("fetch strobe", 24'h1, {23'h0, rd});
    endtask : do_reset
    task automatic t_mode();
        wr(sspm_pkg::SSPM_WR_MOVE, 24'hffffff, 8'h00);
        chk("omr move", 24'hffffdf, operating_mode_register);
        wr(sspm_pkg::SSPM_WR_AND, 24'h0f0f0f, 8'h00);
        chk("omr and", 24'h0f0f0f, operating_mode_register);
        wr(sspm_pkg::SSPM_WR_OR, 24'h000020, 8'h00);
        chk("omr or", 24'h0f0f0f, operating_mode_register);
        wr(sspm_pkg::SSPM_WR_SCS, 24'hffffff, 8'h10);
        chk("omr stack byte", 24'h100f0f, operating_mode_register);
        chk("sen set", 24'h1, {23'h0, stack_extension_enable});
    endtask : t_mode
    task automatic t_pipe();
        repeat (8) @(negedge clk);
        chk("all stages full", 24'h7f, {17'h0, vld});
        chk("decode word", (addr - 24'h2) ^ 24'h5a5a5a, dec);
        chk("program counter", addr + 24'h1, pc);
        haz = 7'h08;
        @(negedge clk);
        haz = 7'h00;
        chk("stall flag", 24'h1, {23'h0, stall});
        chk("bubble in", 24'h6f, {17'h0, vld});
        chk("advance in stall", 24'h60, {17'h0, adv});
        @(negedge clk);
        chk("bubble moves", 24'h5f, {17'h0, vld});
        chk("word after stall", (addr - 24'h2) ^ 24'h5a5a5a, dec);
        @(negedge clk);
        chk("word kept in order", (addr - 24'h2) ^ 24'h5a5a5a, dec);
        chk("counter after stall", addr + 24'h1, pc);
    endtask : t_pipe
    task automatic end_of_test();
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    initial
    begin
        do_reset(4'ha);
        t_mode();
        t_pipe();
        do_reset(4'h5);
        end_of_test();
    end
endmodule : sspm_core_bench
`default_nettype wire
